/* File: afc_pkg.sv */
// shared constants, types and register map of the adc frame integrity host controller
package afc_pkg;

	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int LINK_PERIOD_NS = 400;
	localparam int SCLK_HALF_CYC_I = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [3:0] SCLK_HALF_CYC = 4'(SCLK_HALF_CYC_I - 1);

	// =====================================================================
	// check word
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;

	// =====================================================================
	// word length codes (also strap drive)
	localparam logic [1:0] WL_16 = 2'h0;
	localparam logic [1:0] WL_24 = 2'h1;
	localparam logic [1:0] WL_32 = 2'h2;
	localparam logic [5:0] BITS_16 = 6'h10;
	localparam logic [5:0] BITS_24 = 6'h18;
	localparam logic [5:0] BITS_32 = 6'h20;
	localparam logic [5:0] HAM_BITS = 6'h08;

	// =====================================================================
	// register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FRAME = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_TX_BASE = 8'h20;
	localparam logic [7:0] REG_RX_BASE = 8'h40;
	localparam logic [7:0] REG_MEM_MASK = 8'hE3;
	localparam int MEM_IDX_LSB = 2;
	localparam int MEM_WORDS = 8;

	// control fields
	localparam int CTRL_START = 0;
	localparam int CTRL_CRC_EN = 1;
	localparam int CTRL_FIXED = 2;
	localparam int CTRL_CRC_MODE = 3;
	localparam int CTRL_HAM = 4;
	localparam int CTRL_WL_LSB = 5;
	localparam int CTRL_WAIT_RDY = 7;

	// frame fields
	localparam int FRM_WORDS_LSB = 0;
	localparam int FRM_TX_ACT_LSB = 4;
	localparam int FRM_RX_ACT_LSB = 8;
	localparam int FRM_RX_CRC_LSB = 12;

	// status fields
	localparam int ST_BUSY = 0;
	localparam int ST_CRC_ERR = 1;
	localparam int ST_HAM_FIX = 2;
	localparam int ST_HAM_MULTI = 3;

	// reset values
	localparam logic [3:0] FRM_WORDS_RST = 4'h6;
	localparam logic [3:0] FRM_TX_ACT_RST = 4'h1;
	localparam logic [3:0] FRM_RX_ACT_RST = 4'h5;
	localparam logic [3:0] FRM_RX_CRC_RST = 4'h5;

	// =====================================================================
	// types
	typedef struct packed
	{
		logic wait_rdy;
		logic [1:0] wl;
		logic ham;
		logic crc_mode;
		logic fixed;
		logic crc_en;
	} afc_cfg_s;

	typedef struct packed
	{
		logic [3:0] words;
		logic [3:0] tx_active;
		logic [3:0] rx_active;
		logic [3:0] rx_crc_idx;
	} afc_frame_s;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_WAIT_RDY,
		ST_LOAD,
		ST_SHIFT,
		ST_WORD,
		ST_END
	} afc_state_e;

endpackage : afc_pkg

/* File: afc_crc16.sv */
// bit-serial crc16 engine, msb first
`timescale 1ns/100ps
module afc_crc16
(
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic clear_in,
	input wire logic en_in,
	input wire logic bit_in,
	output logic [15:0] crc_out
);

	// =====================================================================
	// msb-first serial form equals the bytewise shift-and-xor procedure
	logic fb;
	assign fb = crc_out[15] ^ bit_in;

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			crc_out <= afc_pkg::CRC_INIT;
		else if (clear_in)
			crc_out <= afc_pkg::CRC_INIT;
		else if (en_in)
			crc_out <= {crc_out[14:0], 1'b0} ^ (fb ? afc_pkg::CRC_POLY : 16'h0000);
	end

endmodule : afc_crc16

/* File: afc_hamming.sv */
// per-word correction byte: encoder and single-fix / multi-detect decoder
`timescale 1ns/100ps
module afc_hamming
(
	input wire logic [23:0] data_in,
	input wire logic [7:0] code_in,
	output logic [7:0] code_out,
	output logic [23:0] data_out,
	output logic single_out,
	output logic multi_out
);

	// =====================================================================
	// position of data bit n in the interleaved code word, counted from h0 = 1
	function automatic logic [4:0] data_pos(input int n);
		if (n == 23)
			data_pos = 5'(3);
		else if (n >= 20)
			data_pos = 5'(27 - n);
		else if (n >= 13)
			data_pos = 5'(28 - n);
		else
			data_pos = 5'(29 - n);
	endfunction : data_pos

	logic [4:0] h;
	logic [4:0] pos;
	logic [4:0] syn;
	logic par;
	logic rx_par;

	always_comb
	begin
		h = 5'h00;
		pos = 5'h00;
		for (int n = 0; n < 24; n++)
		begin
			pos = data_pos(n);
			for (int k = 0; k < 5; k++)
				if (pos[k])
					h[k] = h[k] ^ data_in[n];
		end
		par = ^{data_in, h};
		code_out = {h, par, ~par, 1'b0};
		syn = h ^ code_in[7:3];
		rx_par = ^{data_in, code_in[7:3], code_in[2]};
		data_out = data_in;
		single_out = 1'b0;
		multi_out = 1'b0;
		if (syn != 5'h00)
		begin
			// odd overall parity flips one bit, even means two or more
			if (rx_par)
			begin
				single_out = 1'b1;
				for (int n = 0; n < 24; n++)
					if (data_pos(n) == syn)
						data_out[n] = ~data_in[n];
			end
			else
				multi_out = 1'b1;
		end
	end

endmodule : afc_hamming

/* File: afc_host.sv */
// host-side controller: frames, check word and correction byte over the serial link
//
// Function
// - The check word sits in the last device word of each frame, both directions.
// - Check word optional, enabled by config bit, upper 16 bits of last word.
// - Check value is CRC16-CCITT, polynomial 11021h, remainder preset to FFFFh.
// - Host zeroes unused input words and puts its check word in the final word.
// - Input coverage: all words unless fixed frame with mode 0, then active only.
// - Output coverage: all words unless fixed frame with mode 0, then active only.
// - With correction byte on, only upper word bits enter the check value.
// - Multi-write frames: check word after extension; device pads later words uncovered.
// - Per byte xor into register, then eight shift steps with 1021h feedback.
// - Host compares check values, flags mismatch as transmission error, software retries.
// - Command and status words carry 16 bits; correction byte in low eight.
// - Correction byte: five code bits, two checksum bits, then a zero.
// - Code corrects any single-bit error and detects multi-bit errors per word.
// - Code positions interleave parity bits h4..h0 among data bits per table.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/100ps
module afc_host
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic sclk_out,
	output logic cs_n_out,
	output logic din_out,
	input wire logic dout_in,
	input wire logic data_ready_n_in,
	output logic word_length_strap_out,
	output logic word_length_strap_oe_out,
	output logic error_correction_strap_out,
	output logic error_correction_strap_oe_out
);

	// =====================================================================
	// registers and state
	afc_pkg::afc_cfg_s digital_system_config_reg;
	afc_pkg::afc_frame_s frame_reg;
	afc_pkg::afc_state_e state_reg;
	logic [23:0] tx_mem [afc_pkg::MEM_WORDS];
	logic [23:0] rx_mem [afc_pkg::MEM_WORDS];
	logic crc_err_reg;
	logic ham_fix_reg;
	logic ham_multi_reg;
	logic [3:0] div_reg;
	logic [5:0] bit_reg;
	logic [3:0] word_reg;
	logic [31:0] tx_sr_reg;
	logic [31:0] rx_sr_reg;
	logic [1:0] dout_sync_reg;
	logic [1:0] rdy_sync_reg;

	// =====================================================================
	// pin synchronisers
	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			dout_sync_reg <= 2'b00;
			rdy_sync_reg <= 2'b11;
		end
		else
		begin
			dout_sync_reg <= {dout_sync_reg[0], dout_in};
			rdy_sync_reg <= {rdy_sync_reg[0], data_ready_n_in};
		end
	end

	// =====================================================================
	// frame geometry
	logic ham_on;
	logic [5:0] word_bits;
	logic [5:0] crc_bits;
	logic full_cov;
	logic tx_crc_word;
	logic tx_cov;
	logic rx_cov;
	logic last_word;

	always_comb
	begin
		case (digital_system_config_reg.wl)
			afc_pkg::WL_32: word_bits = afc_pkg::BITS_32;
			afc_pkg::WL_24: word_bits = afc_pkg::BITS_24;
			default: word_bits = afc_pkg::BITS_16;
		endcase
	end

	// no correction byte with word length code WL_16; code 3 also gives 16-bit words but keeps it
	assign ham_on = digital_system_config_reg.ham && (digital_system_config_reg.wl != afc_pkg::WL_16);
	assign crc_bits = ham_on ? word_bits - afc_pkg::HAM_BITS : word_bits;
	assign full_cov = !digital_system_config_reg.fixed || digital_system_config_reg.crc_mode;
	assign last_word = (word_reg == frame_reg.words - 4'h1);
	assign tx_crc_word = digital_system_config_reg.crc_en && last_word;
	assign tx_cov = !tx_crc_word && (full_cov || word_reg < frame_reg.tx_active);
	assign rx_cov = (word_reg < frame_reg.rx_crc_idx) && (full_cov || word_reg < frame_reg.rx_active);

	// =====================================================================
	// outgoing word build
	logic [15:0] tx_crc;
	logic [15:0] rx_crc;
	logic [23:0] tx_pay;
	logic [23:0] tx_enc_in;
	logic [7:0] tx_code;
	logic [31:0] tx_word;

	always_comb
	begin
		if (tx_crc_word)
			tx_pay = {tx_crc, 8'h00};
		else if (word_reg == 4'h0)
			tx_pay = {tx_mem[0][23:8], 8'h00};
		else if (word_reg < frame_reg.tx_active)
			tx_pay = tx_mem[word_reg[2:0]];
		else
			tx_pay = 24'h00_0000;
		tx_enc_in = (digital_system_config_reg.wl == afc_pkg::WL_32) ? tx_pay : {tx_pay[23:8], 8'h00};
		if (!ham_on)
			tx_word = {tx_pay, 8'h00};
		else if (digital_system_config_reg.wl == afc_pkg::WL_32)
			tx_word = {tx_pay, tx_code};
		else
			tx_word = {tx_pay[23:8], tx_code, 8'h00};
	end

	afc_hamming u_tx_ham
	(
		.data_in(tx_enc_in),
		.code_in(8'h00),
		.code_out(tx_code),
		.data_out(),
		.single_out(),
		.multi_out()
	);

	// =====================================================================
	// incoming word decode, correction before the word is stored
	logic [31:0] rx_aligned;
	logic [23:0] rx_dec_in;
	logic [7:0] rx_code;
	logic [23:0] rx_fixed;
	logic rx_single;
	logic rx_multi;
	logic [23:0] rx_value;

	assign rx_aligned = rx_sr_reg << (afc_pkg::BITS_32 - word_bits);
	assign rx_dec_in = (digital_system_config_reg.wl == afc_pkg::WL_32) ? rx_aligned[31:8]
		: {rx_aligned[31:16], 8'h00};
	assign rx_code = (digital_system_config_reg.wl == afc_pkg::WL_32) ? rx_aligned[7:0]
		: rx_aligned[15:8];
	assign rx_value = ham_on ? rx_fixed : rx_aligned[31:8];

	afc_hamming u_rx_ham
	(
		.data_in(rx_dec_in),
		.code_in(rx_code),
		.code_out(),
		.data_out(rx_fixed),
		.single_out(rx_single),
		.multi_out(rx_multi)
	);

	// =====================================================================
	// serial clock phases
	logic half_done;
	logic rise;
	logic fall;
	logic crc_clear;

	assign half_done = (div_reg == afc_pkg::SCLK_HALF_CYC);
	assign rise = (state_reg == afc_pkg::ST_SHIFT) && half_done && !sclk_out;
	assign fall = (state_reg == afc_pkg::ST_SHIFT) && half_done && sclk_out;
	assign crc_clear = (state_reg == afc_pkg::ST_IDLE);

	afc_crc16 u_tx_crc
	(
		.clk_in(mclk_in),
		.resetn_in(resetn_in),
		.clear_in(crc_clear),
		.en_in(rise && tx_cov && (bit_reg < crc_bits)),
		.bit_in(tx_sr_reg[31]),
		.crc_out(tx_crc)
	);

	afc_crc16 u_rx_crc
	(
		.clk_in(mclk_in),
		.resetn_in(resetn_in),
		.clear_in(crc_clear),
		.en_in(fall && rx_cov && (bit_reg < crc_bits)),
		.bit_in(dout_sync_reg[1]),
		.crc_out(rx_crc)
	);

	// =====================================================================
	// frame sequencer
	logic start;
	assign start = wr_in && (addr_in == afc_pkg::REG_CTRL) && wdata_in[afc_pkg::CTRL_START];

	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state_reg <= afc_pkg::ST_IDLE;
			cs_n_out <= 1'b1;
			sclk_out <= 1'b0;
			din_out <= 1'b0;
			div_reg <= 4'h0;
			bit_reg <= 6'h00;
			word_reg <= 4'h0;
			tx_sr_reg <= 32'h0000_0000;
			rx_sr_reg <= 32'h0000_0000;
		end
		else
		begin
			case (state_reg)
				afc_pkg::ST_IDLE:
					if (start)
					begin
						word_reg <= 4'h0;
						state_reg <= wdata_in[afc_pkg::CTRL_WAIT_RDY] ? afc_pkg::ST_WAIT_RDY
							: afc_pkg::ST_LOAD;
					end
				afc_pkg::ST_WAIT_RDY:
					if (!rdy_sync_reg[1])
						state_reg <= afc_pkg::ST_LOAD;
				afc_pkg::ST_LOAD:
				begin
					cs_n_out <= 1'b0;
					tx_sr_reg <= tx_word;
					bit_reg <= 6'h00;
					div_reg <= 4'h0;
					state_reg <= afc_pkg::ST_SHIFT;
				end
				afc_pkg::ST_SHIFT:
				begin
					div_reg <= half_done ? 4'h0 : div_reg + 4'h1;
					// device shifts on the rising edge and latches on the falling one
					if (rise)
					begin
						sclk_out <= 1'b1;
						din_out <= tx_sr_reg[31];
					end
					if (fall)
					begin
						sclk_out <= 1'b0;
						tx_sr_reg <= {tx_sr_reg[30:0], 1'b0};
						rx_sr_reg <= {rx_sr_reg[30:0], dout_sync_reg[1]};
						bit_reg <= bit_reg + 6'h01;
						if (bit_reg == word_bits - 6'h01)
							state_reg <= afc_pkg::ST_WORD;
					end
				end
				afc_pkg::ST_WORD:
				begin
					word_reg <= word_reg + 4'h1;
					state_reg <= last_word ? afc_pkg::ST_END : afc_pkg::ST_LOAD;
				end
				afc_pkg::ST_END:
				begin
					cs_n_out <= 1'b1;
					din_out <= 1'b0;
					state_reg <= afc_pkg::ST_IDLE;
				end
				default:
					state_reg <= afc_pkg::ST_IDLE;
			endcase
		end
	end

	// =====================================================================
	// received word store and integrity flags; hardware set beats software clear
	logic rx_done;
	logic crc_bad;
	logic clr;

	assign rx_done = (state_reg == afc_pkg::ST_WORD);
	assign crc_bad = rx_done && digital_system_config_reg.crc_en
		&& (word_reg == frame_reg.rx_crc_idx) && (rx_value[23:8] != rx_crc);
	assign clr = wr_in && (addr_in == afc_pkg::REG_STATUS);

	always_ff @(posedge mclk_in)
	begin
		if (rx_done && word_reg < 4'(afc_pkg::MEM_WORDS))
			rx_mem[word_reg[2:0]] <= rx_value;
	end

	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			crc_err_reg <= 1'b0;
			ham_fix_reg <= 1'b0;
			ham_multi_reg <= 1'b0;
		end
		else
		begin
			crc_err_reg <= crc_bad || (crc_err_reg && !(clr && wdata_in[afc_pkg::ST_CRC_ERR]));
			ham_fix_reg <= (rx_done && ham_on && rx_single)
				|| (ham_fix_reg && !(clr && wdata_in[afc_pkg::ST_HAM_FIX]));
			ham_multi_reg <= (rx_done && ham_on && rx_multi)
				|| (ham_multi_reg && !(clr && wdata_in[afc_pkg::ST_HAM_MULTI]));
		end
	end

	// =====================================================================
	// software registers
	logic mem_hit;
	assign mem_hit = ((addr_in & afc_pkg::REG_MEM_MASK) == afc_pkg::REG_TX_BASE);

	always_ff @(posedge mclk_in)
	begin
		if (wr_in && mem_hit)
			tx_mem[addr_in[afc_pkg::MEM_IDX_LSB +: 3]] <= wdata_in[23:0];
	end

	// config changes are held off while a frame runs
	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			digital_system_config_reg <= '0;
			frame_reg <= {afc_pkg::FRM_WORDS_RST, afc_pkg::FRM_TX_ACT_RST,
				afc_pkg::FRM_RX_ACT_RST, afc_pkg::FRM_RX_CRC_RST};
		end
		else if (wr_in && state_reg == afc_pkg::ST_IDLE)
		begin
			if (addr_in == afc_pkg::REG_CTRL)
			begin
				digital_system_config_reg.crc_en <= wdata_in[afc_pkg::CTRL_CRC_EN];
				digital_system_config_reg.fixed <= wdata_in[afc_pkg::CTRL_FIXED];
				digital_system_config_reg.crc_mode <= wdata_in[afc_pkg::CTRL_CRC_MODE];
				digital_system_config_reg.ham <= wdata_in[afc_pkg::CTRL_HAM];
				digital_system_config_reg.wl <= wdata_in[afc_pkg::CTRL_WL_LSB +: 2];
				digital_system_config_reg.wait_rdy <= wdata_in[afc_pkg::CTRL_WAIT_RDY];
			end
			if (addr_in == afc_pkg::REG_FRAME)
			begin
				frame_reg.words <= wdata_in[afc_pkg::FRM_WORDS_LSB +: 4];
				frame_reg.tx_active <= wdata_in[afc_pkg::FRM_TX_ACT_LSB +: 4];
				frame_reg.rx_active <= wdata_in[afc_pkg::FRM_RX_ACT_LSB +: 4];
				frame_reg.rx_crc_idx <= wdata_in[afc_pkg::FRM_RX_CRC_LSB +: 4];
			end
		end
	end

	// straps follow config; device latches them at its own power-up
	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			word_length_strap_out <= 1'b0;
			word_length_strap_oe_out <= 1'b0;
			error_correction_strap_out <= 1'b0;
			error_correction_strap_oe_out <= 1'b0;
		end
		else
		begin
			word_length_strap_out <= (digital_system_config_reg.wl == afc_pkg::WL_32);
			word_length_strap_oe_out <= (digital_system_config_reg.wl != afc_pkg::WL_16);
			error_correction_strap_out <= ham_on;
			error_correction_strap_oe_out <= 1'b1;
		end
	end

	logic [31:0] rdata_next;
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (mem_hit)
			rdata_next = {8'h00, tx_mem[addr_in[afc_pkg::MEM_IDX_LSB +: 3]]};
		else if ((addr_in & afc_pkg::REG_MEM_MASK) == afc_pkg::REG_RX_BASE)
			rdata_next = {8'h00, rx_mem[addr_in[afc_pkg::MEM_IDX_LSB +: 3]]};
		else if (addr_in == afc_pkg::REG_CTRL)
			rdata_next = {24'h00_0000, digital_system_config_reg.wait_rdy,
				digital_system_config_reg.wl, digital_system_config_reg.ham,
				digital_system_config_reg.crc_mode, digital_system_config_reg.fixed,
				digital_system_config_reg.crc_en, 1'b0};
		else if (addr_in == afc_pkg::REG_FRAME)
			rdata_next = {16'h0000, frame_reg.rx_crc_idx, frame_reg.rx_active,
				frame_reg.tx_active, frame_reg.words};
		else if (addr_in == afc_pkg::REG_STATUS)
			rdata_next = {28'h000_0000, ham_multi_reg, ham_fix_reg, crc_err_reg,
				state_reg != afc_pkg::ST_IDLE};
	end

	always_ff @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rdata_out <= 32'h0000_0000;
		else if (rd_in)
			rdata_out <= rdata_next;
		else
			rdata_out <= 32'h0000_0000;
	end

endmodule : afc_host

/* File: afc_host_asserts.sv */
// concurrent checks on the ports of the frame integrity host controller
`timescale 1ns/100ps
module afc_host_asserts
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic [7:0] addr_in,
	input wire logic rd_in,
	input wire logic [31:0] rdata_out,
	input wire logic sclk_out,
	input wire logic cs_n_out,
	input wire logic din_out,
	input wire logic word_length_strap_out,
	input wire logic word_length_strap_oe_out,
	input wire logic error_correction_strap_out,
	input wire logic error_correction_strap_oe_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	// =====================================================================
	// link clock shape
	sequence s_high_run;
		sclk_out[*4] ##1 !sclk_out;
	endsequence
	sequence s_low_run;
		(!sclk_out)[*4];
	endsequence
	a_sclk_high_time: assert property ($rose(sclk_out) |-> s_high_run)
		else $error("serial clock high phase wrong");
	a_sclk_low_time: assert property ($fell(sclk_out) |-> s_low_run)
		else $error("serial clock low phase too short");
	a_sclk_in_frame: assert property (sclk_out |-> !cs_n_out)
		else $error("serial clock outside frame");
	// device latches on the fall, so data may only move on the rise
	a_din_at_rise: assert property (!cs_n_out && $changed(din_out) |-> $rose(sclk_out))
		else $error("data out moved away from clock rise");
	a_frame_close: assert property ($rose(cs_n_out) |-> !sclk_out && !din_out)
		else $error("frame closed with clock or data high");
	// =====================================================================
	// register port and straps
	a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0000_0000)
		else $error("read data without read strobe");
	a_unmapped_zero: assert property (rd_in && addr_in == 8'h10 |=> rdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_ecc_strap_drive: assert property ($past(resetn_in) |-> error_correction_strap_oe_out)
		else $error("correction strap not driven");
	a_strap_hold: assert property (!cs_n_out |-> $stable({word_length_strap_out,
		word_length_strap_oe_out, error_correction_strap_out}))
		else $error("strap moved during frame");
endmodule : afc_host_asserts

bind afc_host afc_host_asserts afc_host_asserts_i (.mclk_in, .resetn_in, .addr_in, .rd_in,
	.rdata_out, .sclk_out, .cs_n_out, .din_out, .word_length_strap_out,
	.word_length_strap_oe_out, .error_correction_strap_out, .error_correction_strap_oe_out);

/* File: afc_dev_model.sv */
// behavioural converter: 24-bit words, check word on both data lines
`timescale 1ns/100ps
module afc_dev_model
(
	input wire logic sclk_in,
	input wire logic cs_n_in,
	input wire logic din_in,
	input wire logic [191:0] words_in,
	input wire logic [3:0] nw_in,
	input wire logic [3:0] cov_o_in,
	input wire logic [3:0] cov_i_in,
	input wire logic en_in,
	input wire logic bad_in,
	output logic dout_out,
	output logic data_ready_n_out,
	output logic fault_out
);
	logic [191:0] tx_vec = '0;
	logic [191:0] rx_vec = '0;
	logic [191:0] v;
	logic [15:0] c;
	initial dout_out = 1'b0;
	initial data_ready_n_out = 1'b0;
	initial fault_out = 1'b0;

	// bit-serial form of the per-byte loop, msb first
	function automatic logic [15:0] crc_f(input logic [191:0] d, input int n);
		logic [15:0] r;
		r = 16'hFFFF;
		for (int i = 0; i < n * 24; i++)
			r = {r[14:0], 1'b0} ^ ((r[15] ^ d[191 - i]) ? 16'h1021 : 16'h0000);
		return r;
	endfunction : crc_f

	// =====================================================================
	// output frame: signed codes as given, check word in last word
	always @(negedge cs_n_in)
	begin
		tx_vec = words_in;
		c = crc_f(words_in, cov_o_in);
		if (en_in)
			tx_vec[191 - 24 * (nw_in - 1) -: 24] = {c ^ {16{bad_in}}, 8'h00};
		rx_vec = '0;
	end
	always @(posedge sclk_in)
		if (!cs_n_in)
		begin
			dout_out <= tx_vec[191];
			tx_vec <= tx_vec << 1;
		end
	always @(negedge sclk_in)
		if (!cs_n_in)
			rx_vec <= {rx_vec[190:0], din_in};
	// =====================================================================
	// input check at frame end; line released, no pull, so it flips
	always @(posedge cs_n_in)
	begin
		dout_out <= ~dout_out;
		data_ready_n_out <= 1'b1;
		data_ready_n_out <= #3000 1'b0;
		v = rx_vec << (192 - 24 * nw_in);
		c = crc_f(v, cov_i_in);
		fault_out <= en_in && (c !== v[191 - 24 * (nw_in - 1) -: 16]);
	end
endmodule : afc_dev_model

/* File: tb_afc_host.sv */
// self-checking bench for the frame integrity host controller
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_afc_host;
	logic mclk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic [31:0] rdata_out;
	logic sclk, cs_n, din, dout, rdy_n, fault, wl, wl_oe, ec, ec_oe;
	logic [191:0] words = '0;
	logic [3:0] nw = 4'h6;
	logic [3:0] cov_o = 4'h5;
	logic [3:0] cov_i = 4'h5;
	logic en = 1'b0;
	logic bad = 1'b0;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	afc_host afc_host_i (.mclk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout),
		.data_ready_n_in(rdy_n), .word_length_strap_out(wl), .word_length_strap_oe_out(wl_oe),
		.error_correction_strap_out(ec), .error_correction_strap_oe_out(ec_oe));
	afc_dev_model afc_dev_model_i (.sclk_in(sclk), .cs_n_in(cs_n), .din_in(din),
		.words_in(words), .nw_in(nw), .cov_o_in(cov_o), .cov_i_in(cov_i), .en_in(en),
		.bad_in(bad), .dout_out(dout), .data_ready_n_out(rdy_n), .fault_out(fault));

	initial forever #25 mclk_in = ~mclk_in;
	// frames run about 1200 cycles each; the ceiling leaves ample room
	always @(posedge mclk_in)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			num_errors++;
			test_done();
		end
	end

	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done

	// =====================================================================
	// register port
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
		@(posedge mclk_in);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
		@(posedge mclk_in);
	endtask : rd
	task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`CHK(n, e, d)
	endtask : chk_rd

	// =====================================================================
	// one frame; tx words past the covered ones are left zero
	task automatic frame(input logic [7:0] ctl, input logic [15:0] frm, input logic [3:0] co,
		input logic [3:0] ci, input logic e, input logic b, input logic err);
		logic [31:0] s;
		cov_o = co;
		cov_i = ci;
		en = e;
		bad = b;
		wr(8'h04, {16'h0000, frm});
		for (int i = 0; i < 8; i++)
			wr(8'h20 + 8'(4 * i), (i < ci) ? 32'(24'h5A_0F00 ^ 24'(i * 3)) : 32'h0000_0000);
		wr(8'h00, {24'h00_0000, ctl});
		s = 32'h0000_0001;
		for (int k = 0; k < 2000 && s[0] !== 1'b0; k++)
			rd(8'h08, s);
		`CHK("busy", 1'b0, s[0])
		`CHK("rx check", err, s[1])
		`CHK("dev check", 1'b0, fault)
		for (int i = 0; i < 5; i++)
			chk_rd("rx word", 8'h40 + 8'(4 * i), {8'h00, words[191 - 24 * i -: 24]});
		wr(8'h08, 32'h0000_000E);
		chk_rd("status clr", 8'h08, 32'h0000_0000);
	endtask : frame

	task automatic straps();
		for (int w = 0; w < 3; w++)
		begin
			wr(8'h00, {24'h00_0000, 1'b0, 2'(w), 1'(w != 0), 4'h0});
			// straps settle one edge after the config write lands
			#1;
			`CHK("wl oe", 1'(w != 0), wl_oe)
			`CHK("wl out", 1'(w == 2), wl)
			`CHK("ec out", 1'(w != 0), ec)
		end
		wr(8'h00, 32'h0000_0020);
		#1;
		`CHK("ec off", 1'b0, ec)
	endtask : straps

	initial
	begin
		repeat (3) @(posedge mclk_in);
		resetn_in <= 1'b1;
		@(posedge mclk_in);
		chk_rd("frame rst", 8'h04, 32'h0000_5516);
		chk_rd("status rst", 8'h08, 32'h0000_0000);
		chk_rd("unmapped", 8'h10, 32'h0000_0000);
		`CHK("ec oe", 1'b1, ec_oe)
		`CHK("wl float", 1'b0, wl_oe)
		straps();
		// clipping codes and one step below zero
		words = {24'h12_3400, 24'h7F_FFFF, 24'h80_0000, 24'hFF_FFFF, 24'h00_0001, 72'h0};
		frame(8'h23, 16'h5516, 4'h5, 4'h5, 1'b1, 1'b0, 1'b0);
		frame(8'h23, 16'h5516, 4'h5, 4'h5, 1'b1, 1'b1, 1'b1);
		// waits for the ready line the model drops after the previous frame
		frame(8'hAF, 16'h5516, 4'h5, 4'h5, 1'b1, 1'b0, 1'b0);
		frame(8'h27, 16'h5316, 4'h3, 4'h1, 1'b1, 1'b0, 1'b0);
		frame(8'h21, 16'h5516, 4'h5, 4'h5, 1'b0, 1'b1, 1'b0);
		test_done();
	end
endmodule : tb_afc_host
